// ===== fps_pkg.sv
// Shared constants and types for the flyback protection supervisor
package fps_pkg;

  // Clock and counter sizing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CNT_W         = 28;
  typedef logic [CNT_W-1:0] fps_cnt_t;

  // Qualifying times, in ns as specified
  localparam int T_SUPPLY_NS   = 10000;      // Low and high supply
  localparam int T_TSD_NS      = 10000;      // Thermal shutdown
  localparam int T_EXT65_NS    = 55000;      // External event, 65 kHz
  localparam int T_EXT100_NS   = 35000;      // External event, 100 kHz
  localparam int T_LHI65_NS    = 50000;      // High latch, 65 kHz
  localparam int T_LHI100_NS   = 50000;      // High latch, 100 kHz
  localparam int T_LLO_NS      = 350000;     // Low latch
  localparam int T_FBOFF_NS    = 150000000;  // Feedback off mode
  localparam int T_FAULT_NS    = 128000000;  // Overload fault timer
  localparam int T_AUTOREC_NS  = 1000000000; // Autorecovery delay
  localparam int T_LINE_NS     = 20000000;   // Line brown-out timer
  localparam int T_SSTART_NS   = 10000000;   // Soft-start period

  // Least times round up to whole cycles
  localparam int CP  = CLK_PERIOD_NS;
  localparam int RND = CLK_PERIOD_NS - 1;
  localparam fps_cnt_t SUPPLY_CYC  = fps_cnt_t'((T_SUPPLY_NS + RND) / CP);
  localparam fps_cnt_t TSD_CYC     = fps_cnt_t'((T_TSD_NS + RND) / CP);
  localparam fps_cnt_t EXT65_CYC   = fps_cnt_t'((T_EXT65_NS + RND) / CP);
  localparam fps_cnt_t EXT100_CYC  = fps_cnt_t'((T_EXT100_NS + RND) / CP);
  localparam fps_cnt_t LHI65_CYC   = fps_cnt_t'((T_LHI65_NS + RND) / CP);
  localparam fps_cnt_t LHI100_CYC  = fps_cnt_t'((T_LHI100_NS + RND) / CP);
  localparam fps_cnt_t LLO_CYC     = fps_cnt_t'((T_LLO_NS + RND) / CP);
  localparam fps_cnt_t FBOFF_CYC   = fps_cnt_t'((T_FBOFF_NS + RND) / CP);
  localparam fps_cnt_t FAULT_CYC   = fps_cnt_t'((T_FAULT_NS + RND) / CP);
  localparam fps_cnt_t AUTOREC_CYC = fps_cnt_t'((T_AUTOREC_NS + RND) / CP);
  localparam fps_cnt_t LINE_CYC    = fps_cnt_t'((T_LINE_NS + RND) / CP);
  localparam fps_cnt_t SSTART_CYC  = fps_cnt_t'((T_SSTART_NS + RND) / CP);

  // Comparator flags and static selects, all from pins
  typedef struct packed {
    logic pwm_request;      // Gate request from the PWM path
    logic ilim_clamp;       // Setpoint clamped at current_limit_level
    logic max_on_end;       // Last pulse ended by maximum on-time
    logic winding_short;    // Sense above winding-short level
    logic supply_low;       // Below supply_undervoltage_level
    logic supply_high;      // Above supply_overvoltage_level
    logic supply_start;     // Above supply_start_level
    logic supply_reset;     // Below supply_reset_level
    logic ext_event;        // External over-temperature or over-voltage
    logic line_low;         // Below line_stop_level
    logic line_ok;          // Above line_start_level
    logic thermal_shutdown; // Die too hot
    logic thermal_ok_flag;  // Die cooled below low threshold
    logic fb_off;           // Feedback below off level
    logic fb_on;            // Feedback above on level
    logic latch_high;       // Latch-off input above high threshold
    logic latch_low;        // Latch-off input below low threshold
    logic autorec_sel;      // 1: autorecovery variant
    logic freq_100k_sel;    // 1: 100 kHz timing constants
  } fps_flags_t;

  // Latch causes
  typedef struct packed {
    logic overcurrent;
    logic max_on;
    logic winding_short;
    logic supply_low;
    logic external;
    logic supply_high;
    logic latch_input;
  } fps_cause_t;

  // Supervisor states
  typedef enum logic [2:0] {
    ST_WAIT_START,
    ST_SOFTSTART,
    ST_RUN,
    ST_LATCH,
    ST_STOP_LINE,
    ST_STOP_THERM,
    ST_OFF_MODE
  } fps_state_t;

  // Status seen from outside
  typedef struct packed {
    fps_state_t state;
    logic       latched;
    logic       auto_release_ok;
    fps_cause_t cause;
  } fps_status_t;

endpackage

// ===== fps_qual_timer.sv
// Qualifying timer: flags a condition held for a given number of cycles
`timescale 1ns/1ns
module fps_qual_timer (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Condition and length
  input  wire logic             cond,
  input  wire fps_pkg::fps_cnt_t limit,
  // Qualified result
  output logic                  done
);
  import fps_pkg::*;

  fps_cnt_t cnt_reg;

  // Count while held, clear the moment it drops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (!cond) begin
      cnt_reg <= '0;
    end else if (cnt_reg != limit) begin
      cnt_reg <= cnt_reg + fps_cnt_t'(1);
    end
  end

  // Held for limit cycles and still present
  assign done = cond && (cnt_reg == limit);

endmodule

// ===== fps_supervisor.sv
// Protection and latch supervisor for a flyback controller
`timescale 1ns/1ns
// Operation
// - Current limit clamp runs fault timer; expiry stops gate and latches.
// - Maximum on-time termination also runs the fault timer, same latch.
// - Winding short latches at once, no timer.
// - Low supply held 10 us latches; autorecovery, brown-out, reset release.
// - External event held 55 us (35 us) latches; never autoreleased.
// - High supply held 10 us latches; only brown-out, reset or qualified thermal stop release.
// - Autorecovery variant releases fault latches; latched one holds them.
// - Qualified line low stops; restart needs line and supply start.
// - Thermal flag held 10 us stops, source off; restart needs thermal ok.
// - Feedback off 150 ms stops, cuts supply; restart needs feedback on.
// - Latch input outside its window latches the controller off.
// - Blank high latch pulses under 50 us, low under 350 us.
// - Latch-off cleared only by brown-out, supply reset or qualified thermal stop.
// - Latch input ignored before supply start; high latch blocks the start from wait-start only.
// - Low latch detector ignored until soft-start completes.
// - Doubled thermistor pull-up current during soft-start only.
// - Thermal flag stops gate at once; thermal stop keeps supply.
// - Thermal flag cleared: restart through the normal soft-start.
// - Fault timer clears when the clamp goes away before expiry.
// - Autorecovery waits its delay then restarts; lasting fault repeats.
module fps_supervisor #(
  parameter fps_pkg::fps_cnt_t EXT65_LIM   = fps_pkg::EXT65_CYC,
  parameter fps_pkg::fps_cnt_t EXT100_LIM  = fps_pkg::EXT100_CYC,
  parameter fps_pkg::fps_cnt_t LHI65_LIM   = fps_pkg::LHI65_CYC,
  parameter fps_pkg::fps_cnt_t LHI100_LIM  = fps_pkg::LHI100_CYC,
  parameter fps_pkg::fps_cnt_t LLO_LIM     = fps_pkg::LLO_CYC,
  parameter fps_pkg::fps_cnt_t FBOFF_LIM   = fps_pkg::FBOFF_CYC,
  parameter fps_pkg::fps_cnt_t FAULT_LIM   = fps_pkg::FAULT_CYC,
  parameter fps_pkg::fps_cnt_t AUTOREC_LIM = fps_pkg::AUTOREC_CYC,
  parameter fps_pkg::fps_cnt_t LINE_LIM    = fps_pkg::LINE_CYC,
  parameter fps_pkg::fps_cnt_t SSTART_LIM  = fps_pkg::SSTART_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Comparator flags and selects
  input  wire fps_pkg::fps_flags_t flags_in,
  // Power-stage controls
  output logic                     gate_drive_output,
  output logic                     hv_source_en,
  output logic                     internal_supply_en,
  output logic                     softstart_active,
  output logic                     softstart_pullup_current,
  // Status
  output fps_pkg::fps_status_t     status
);
  import fps_pkg::*;

  localparam fps_cnt_t SUPPLY_LIM = fps_cnt_t'(SUPPLY_CYC);
  localparam fps_cnt_t TSD_LIM    = fps_cnt_t'(TSD_CYC);

  fps_flags_t flags_meta_reg;
  fps_flags_t f;
  fps_state_t state_reg;
  fps_state_t state_next;
  fps_cause_t cause_reg;
  fps_cause_t cause_now;
  logic       auto_ok_reg;
  logic       gate_reg;
  logic       hv_en_reg;
  logic       isup_en_reg;
  logic       ss_reg;
  logic       running;
  logic       armed;
  logic       fault_cond;
  logic       fault_done;
  logic       ulo_done;
  logic       uhi_done;
  logic       ext_done;
  logic       lhi_done;
  logic       llo_done;
  logic       line_done;
  logic       tsd_done;
  logic       fboff_done;
  logic       ss_done;
  logic       autorec_done;
  logic       latch_event;
  logic       cause_auto;
  fps_cnt_t   ext_lim;
  fps_cnt_t   lhi_lim;

  // Two-flop synchroniser on every pin flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_meta_reg <= '0;
      f              <= '0;
    end else begin
      flags_meta_reg <= flags_in;
      f              <= flags_meta_reg;
    end
  end

  // Switching states and latch-input arming
  assign running = (state_reg == ST_SOFTSTART) || (state_reg == ST_RUN);
  assign armed   = running || ((state_reg == ST_WAIT_START) && f.supply_start);

  assign ext_lim = f.freq_100k_sel ? EXT100_LIM : EXT65_LIM;
  assign lhi_lim = f.freq_100k_sel ? LHI100_LIM : LHI65_LIM;

  // Clamp or on-time end feeds one timer
  assign fault_cond = running && (f.ilim_clamp || f.max_on_end);

  fps_qual_timer u_fault (.clk(clk), .resetn(resetn), .limit(FAULT_LIM),
    .cond(fault_cond), .done(fault_done));

  fps_qual_timer u_ulo (.clk(clk), .resetn(resetn), .limit(SUPPLY_LIM),
    .cond(running && f.supply_low), .done(ulo_done));

  fps_qual_timer u_uhi (.clk(clk), .resetn(resetn), .limit(SUPPLY_LIM),
    .cond(running && f.supply_high), .done(uhi_done));

  fps_qual_timer u_ext (.clk(clk), .resetn(resetn), .limit(ext_lim),
    .cond(running && f.ext_event), .done(ext_done));

  fps_qual_timer u_lhi (.clk(clk), .resetn(resetn), .limit(lhi_lim),
    .cond(armed && f.latch_high), .done(lhi_done));

  fps_qual_timer u_llo (.clk(clk), .resetn(resetn), .limit(LLO_LIM),
    .cond((state_reg == ST_RUN) && f.latch_low), .done(llo_done));

  fps_qual_timer u_line (.clk(clk), .resetn(resetn), .limit(LINE_LIM),
    .cond(f.line_low), .done(line_done));

  fps_qual_timer u_tsd (.clk(clk), .resetn(resetn), .limit(TSD_LIM),
    .cond(f.thermal_shutdown), .done(tsd_done));

  fps_qual_timer u_fboff (.clk(clk), .resetn(resetn), .limit(FBOFF_LIM),
    .cond(running && f.fb_off), .done(fboff_done));

  // Soft-start period
  fps_qual_timer u_ss (.clk(clk), .resetn(resetn), .limit(SSTART_LIM),
    .cond(state_reg == ST_SOFTSTART), .done(ss_done));

  fps_qual_timer u_autorec (.clk(clk), .resetn(resetn), .limit(AUTOREC_LIM),
    .cond((state_reg == ST_LATCH) && auto_ok_reg), .done(autorec_done));

  // Causes present this cycle
  always_comb begin
    cause_now               = '0;
    cause_now.overcurrent   = fault_done && f.ilim_clamp;
    cause_now.max_on        = fault_done && !f.ilim_clamp;
    cause_now.winding_short = running && f.winding_short;
    cause_now.supply_low    = ulo_done;
    cause_now.external      = ext_done;
    cause_now.supply_high   = uhi_done;
    cause_now.latch_input   = lhi_done || llo_done;
  end

  assign latch_event = |cause_now;
  assign cause_auto  = !(cause_now.external || cause_now.supply_high ||
                         cause_now.latch_input);

  // Next-state decision, resets and brown-out first
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT_START: begin
        // Start only with no high latch
        if (f.supply_start && f.line_ok && !f.latch_high) begin
          state_next = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART: begin
        if (ss_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      ST_LATCH: begin
        if (autorec_done) begin
          state_next = ST_WAIT_START;
        end
      end
      ST_STOP_LINE: begin
        if (f.line_ok && f.supply_start) begin
          state_next = ST_SOFTSTART;
        end
      end
      ST_STOP_THERM: begin
        if (f.line_ok && f.supply_start && f.thermal_ok_flag) begin
          state_next = ST_SOFTSTART;
        end
      end
      ST_OFF_MODE: begin
        if (f.line_ok && f.supply_start && f.fb_on) begin
          state_next = ST_SOFTSTART;
        end
      end
      default: begin
        state_next = ST_WAIT_START;
      end
    endcase
    // Brown-out or supply reset clear every latch
    if (f.supply_reset) begin
      state_next = ST_WAIT_START;
    end else if (line_done) begin
      state_next = ST_STOP_LINE;
    end else if (tsd_done) begin
      state_next = ST_STOP_THERM;
    end else if (armed && latch_event) begin
      state_next = ST_LATCH;
    end else if (running && fboff_done) begin
      state_next = ST_OFF_MODE;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_WAIT_START;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latch cause capture and release eligibility
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_reg   <= '0;
      auto_ok_reg <= 1'b0;
    end else if (state_next != ST_LATCH) begin
      cause_reg   <= '0;
      auto_ok_reg <= 1'b0;
    end else if (state_reg != ST_LATCH) begin
      cause_reg   <= cause_now;
      auto_ok_reg <= f.autorec_sel && cause_auto;
    end
  end

  // Gate drive, stopped at once on any fault or hot die
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_reg <= 1'b0;
    end else begin
      gate_reg <= f.pwm_request && running && (state_next != ST_LATCH) &&
                  !f.thermal_shutdown && !f.winding_short;
    end
  end

  // Supply and start-up source controls
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hv_en_reg   <= 1'b1;
      isup_en_reg <= 1'b1;
    end else begin
      hv_en_reg   <= (state_next != ST_STOP_THERM);
      // Internal supply off in off mode
      isup_en_reg <= (state_next != ST_OFF_MODE);
    end
  end

  // Soft-start indicator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ss_reg <= 1'b0;
    end else begin
      ss_reg <= (state_next == ST_SOFTSTART);
    end
  end

  // Outputs
  assign gate_drive_output        = gate_reg;
  assign hv_source_en             = hv_en_reg;
  assign internal_supply_en       = isup_en_reg;
  assign softstart_active         = ss_reg;
  assign softstart_pullup_current = ss_reg;
  // Status word: state, latched, release eligibility, cause
  assign status = {state_reg, state_reg == ST_LATCH, auto_ok_reg, cause_reg};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_running_quiet;
    running && !f.supply_reset && !line_done && !tsd_done;
  endsequence

  sequence s_fault_restart;
    !fault_cond ##1 fault_cond;
  endsequence

  a_short_latch: assert property (
    s_running_quiet and f.winding_short |=> state_reg == ST_LATCH)
    else $error("winding short did not latch");

  a_fault_latch: assert property (
    s_running_quiet and fault_done |=> state_reg == ST_LATCH ##1 !gate_reg)
    else $error("fault expiry did not latch and stop gate");

  a_timer_clear: assert property (
    s_fault_restart |-> !fault_done [*8])
    else $error("fault timer not cleared");

  a_ext_noauto: assert property (
    state_reg == ST_LATCH && (cause_reg.external || cause_reg.supply_high)
    |-> !auto_ok_reg)
    else $error("external or high supply latch autoreleasable");

  a_latched_holds: assert property (
    state_reg == ST_LATCH && !auto_ok_reg && !f.supply_reset && !line_done
    && !tsd_done |=> state_reg == ST_LATCH)
    else $error("latched variant released");

  a_therm_source: assert property (
    state_reg == ST_STOP_THERM |-> !hv_source_en && !gate_drive_output)
    else $error("start-up source on when hot");

  a_off_supply: assert property (
    state_reg == ST_OFF_MODE |-> !internal_supply_en)
    else $error("internal supply on in off mode");

  a_low_ignored: assert property (
    state_reg == ST_SOFTSTART |-> !llo_done)
    else $error("low latch seen during soft-start");

  a_ntc_double: assert property (
    state_reg == ST_SOFTSTART |-> softstart_pullup_current)
    else $error("pull-up not doubled in soft-start");

  a_high_blocks: assert property (
    state_reg == ST_WAIT_START && f.latch_high |=> state_reg != ST_SOFTSTART)
    else $error("switching began with high latch present");

  a_auto_retry: assert property (
    state_reg == ST_LATCH && autorec_done && !f.supply_reset && !line_done
    && !tsd_done |=> state_reg == ST_WAIT_START)
    else $error("autorecovery did not retry");

endmodule

// ===== tb_top.sv
// Self-checking testbench for the flyback protection supervisor
`timescale 1ns/1ns
module tb_top;
  import fps_pkg::*;
  localparam int LE = 20, LH = 16, LO = 20, LF = 24, LA = 50;
  localparam int LS = 40, LL = 18, LB = 30, LQ = 1250;
  localparam fps_flags_t BASE = 19'h41150;
  typedef struct {
    fps_flags_t m;
    int         lim;
    fps_state_t s;
    fps_cause_t c;
    logic       hv;
    logic       sp;
  } fps_row_t;

  logic        clk;
  logic        resetn;
  logic        gate;
  logic        hv;
  logic        sup;
  logic        ss;
  logic        pull;
  fps_flags_t  fl;
  fps_status_t st;
  logic        auto_exp;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc_cnt = 0;

  // Cause flags beside the state, cause and supplies they should give
  fps_row_t rows[12] = '{
    '{19'h20000, LF, ST_LATCH, 7'h40, 1'b1, 1'b1},      // Current clamp
    '{19'h10000, LF, ST_LATCH, 7'h20, 1'b1, 1'b1},      // Max on-time
    '{19'h08000, 0, ST_LATCH, 7'h10, 1'b1, 1'b1},       // Winding short
    '{19'h04000, LQ, ST_LATCH, 7'h08, 1'b1, 1'b1},      // Supply low
    '{19'h02000, LQ, ST_LATCH, 7'h02, 1'b1, 1'b1},      // Supply high
    '{19'h00400, LE, ST_LATCH, 7'h04, 1'b1, 1'b1},      // External, 65k
    '{19'h00401, 12, ST_LATCH, 7'h04, 1'b1, 1'b1},      // External, 100k
    '{19'h00008, LH, ST_LATCH, 7'h01, 1'b1, 1'b1},      // High latch
    '{19'h00004, LO, ST_LATCH, 7'h01, 1'b1, 1'b1},      // Low latch
    '{19'h00300, LL, ST_STOP_LINE, 7'h00, 1'b1, 1'b1},  // Brown-out
    '{19'h000c0, LQ, ST_STOP_THERM, 7'h00, 1'b0, 1'b1}, // Thermal
    '{19'h00030, LB, ST_OFF_MODE, 7'h00, 1'b1, 1'b0}    // Feedback off
  };

  fps_supervisor #(
    .EXT65_LIM   (fps_cnt_t'(LE)),
    .EXT100_LIM  (28'hc),
    .LHI65_LIM   (fps_cnt_t'(LH)),
    .LHI100_LIM  (fps_cnt_t'(LH)),
    .LLO_LIM     (fps_cnt_t'(LO)),
    .FBOFF_LIM   (fps_cnt_t'(LB)),
    .FAULT_LIM   (fps_cnt_t'(LF)),
    .AUTOREC_LIM (fps_cnt_t'(LA)),
    .LINE_LIM    (fps_cnt_t'(LL)),
    .SSTART_LIM  (fps_cnt_t'(LS))
  ) DUT (
    .clk                      (clk),
    .resetn                   (resetn),
    .flags_in                 (fl),
    .gate_drive_output        (gate),
    .hv_source_en             (hv),
    .internal_supply_en       (sup),
    .softstart_active         (ss),
    .softstart_pullup_current (pull),
    .status                   (st)
  );

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task automatic report_and_stop;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  // Comparison helpers
  task automatic fail(string s);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic chk_b(logic g, logic e, string s);
    comparisons++;
    if (g !== e) fail(s);
  endtask
  task automatic chk_s(fps_state_t g, fps_state_t e, string s);
    comparisons++;
    if (g !== e) fail(s);
  endtask
  task automatic chk_c(fps_cause_t g, fps_cause_t e, string s);
    comparisons++;
    if (g !== e) fail(s);
  endtask

  // Inputs move a fixed 1 ns after the rising edge
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_st(fps_state_t s, int n);
    for (int i = 0; i < n && st.state !== s; i++) cyc(1);
    chk_s(st.state, s, "state not reached");
  endtask
  task automatic do_reset(fps_flags_t f);
    resetn = 1'b0;
    fl = f;
    cyc(12);
    chk_b(gate, 1'b0, "gate in reset");
    chk_b(hv, 1'b1, "source in reset");
    chk_s(st.state, ST_WAIT_START, "state in reset");
    resetn = 1'b1;
  endtask
  task automatic start;
    wait_st(ST_SOFTSTART, 20);
    cyc(2);
    chk_b(pull, 1'b1, "no doubled pull-up");
    chk_b(ss, 1'b1, "no soft-start flag");
    wait_st(ST_RUN, LS + 10);
    cyc(6);
    chk_b(pull, 1'b0, "pull-up stays doubled");
    chk_b(gate, 1'b1, "gate idle in run");
  endtask
  // Stop, partial restart condition, then full restart
  task automatic restart(fps_flags_t sm, fps_flags_t pm, fps_state_t s,
                         int lim);
    do_reset(BASE);
    start();
    fl = BASE ^ sm;
    cyc(6);
    if (s == ST_STOP_THERM) chk_b(gate, 1'b0, "gate late");
    wait_st(s, lim + 14);
    fl = BASE ^ pm;
    cyc(20);
    chk_s(st.state, s, "restart too early");
    fl = BASE;
    wait_st(ST_SOFTSTART, 20);
  endtask

  initial begin
    resetn = 1'b0;
    fl = BASE;
    // Table rows, latched variant then autorecovery variant
    for (int k = 0; k < 2; k++) begin
      foreach (rows[i]) begin
        if (k == 1 && rows[i].s != ST_LATCH) continue;
        do_reset(BASE | (rows[i].m & 19'h00003) | 19'(k << 1));
        start();
        fl = fl ^ (rows[i].m & ~19'h00003);
        if (rows[i].lim > 0) begin
          cyc(rows[i].lim);
          chk_s(st.state, ST_RUN, "stopped early");
        end
        wait_st(rows[i].s, 8);
        cyc(2);
        chk_b(gate, 1'b0, "gate after stop");
        chk_b(hv, rows[i].hv, "source enable");
        chk_b(sup, rows[i].sp, "internal supply");
        chk_b(st.latched, rows[i].s == ST_LATCH, "latched flag");
        if (rows[i].s != ST_LATCH) continue;
        chk_c(st.cause, rows[i].c, "latch cause");
        auto_exp = (k == 1) && ((rows[i].c & 7'h07) == 7'h00);
        chk_b(st.auto_release_ok, auto_exp, "release ok");
        if (auto_exp) begin
          wait_st(ST_WAIT_START, LA + 5);
          wait_st(ST_SOFTSTART, 4);
        end else begin
          cyc(LA + 5);
          chk_s(st.state, ST_LATCH, "latch released");
        end
      end
    end
    // Stop states, partial then full restart conditions
    restart(19'h00300, 19'h00100, ST_STOP_LINE, LL);
    restart(19'h000c0, 19'h00040, ST_STOP_THERM, LQ);
    restart(19'h00030, 19'h00010, ST_OFF_MODE, LB);
    report_and_stop();
  end
endmodule
